// *** gper_consts.svh ***
// offsets, field positions, reset values and widths for the event router
`ifndef GPER_CONSTS_SVH
`define GPER_CONSTS_SVH
`define GPER_CTRL_OFS        12'h450
`define GPER_STAT_OFS        12'h454
`define GPER_PINCFG_OFS      12'h458
`define GPER_POL_BIT         0
`define GPER_FIRST_PORT_BIT  2
`define GPER_NUM_PORTS       4
`define GPER_PIN_ALT_BIT     0
`define GPER_CTRL_RESET      32'h0000_0000
`define GPER_ADDR_W          12
`endif

// *** gper_event_mon.sv ***
// system-side monitor of the shared event pin
`timescale 1ns/1ns
module gper_event_mon (
  input  wire logic pin_i,   // pin 7 level
  input  wire logic oe_n_i,  // low while driven
  input  wire logic inv_i,   // event active high
  output logic      event_o  // event seen
);
  // released pin sits at its pull-up, never a stale value
  wire logic level = oe_n_i ? 1'b1 : pin_i;
  // the system sees only the pin level, so a released pin may look active
  assign event_o = (level == inv_i);
endmodule : gper_event_mon

// *** gper_pkg.sv ***
// types shared by the event router
package gper_pkg;
  typedef logic [31:0] gper_word_t;
  typedef enum logic [0:0] {GPER_IDLE, GPER_ACK} gper_bus_state_t;
endpackage : gper_pkg

// *** gper_router.sv ***
// event router: diverts hot-plug notifications of ports 2..5 onto a shared pin
// Summary of operation
// RQ1 - The polarity-invert bit makes the shared event output active low when clear, active high when set.
// RQ2 - A set per-port divert bit suppresses that port's in-band hot-plug INTx, MSI and PME notifications.
// RQ3 - With the divert bit set, that port's hot-plug notification asserts the shared event output instead.
// RQ4 - The shared event output leaves on general-purpose pin 7 as its alternate function.
// RQ5 - A read-only status bit per port reads one while that port is asserting the shared event.
// RQ6 - A port's status bit is never set unless its divert bit is set.
// RQ7 - Pin 7 carries the event only while configured for its alternate function.
// RQ8 - The shared event is the OR of all port indications, then polarity applied before the pin.
`timescale 1ns/1ns
`include "gper_consts.svh"
module gper_router #(
  parameter int NUM_PORTS = `GPER_NUM_PORTS
) (
  input  wire logic              SYS_CLK_I,     // core clock, 100 MHz
  input  wire logic              RST_I,         // async reset, active high
  input  wire logic              STICKY_RST_I,  // power-on reset for sticky bits
  input  wire logic [11:0]       ADR_I,         // wishbone byte address
  input  wire gper_pkg::gper_word_t DAT_I,      // wishbone write data
  input  wire logic [3:0]        SEL_I,         // wishbone byte enables
  input  wire logic              WE_I,          // wishbone write
  input  wire logic              CYC_I,         // wishbone cycle
  input  wire logic              STB_I,         // wishbone strobe
  input  wire logic [NUM_PORTS-1:0] HP_EVENT_I, // per-port hot-plug event level
  input  wire logic              GPIO7_IN_I,    // pin 7 input side
  input  wire logic              GPIO7_OUT_I,   // pin 7 output when plain gpio
  input  wire logic              GPIO7_DRV_I,   // pin 7 drive request as gpio
  output gper_pkg::gper_word_t   DAT_O,         // wishbone read data
  output logic                   ACK_O,         // wishbone acknowledge
  output logic                   ERR_O,         // wishbone error, unmapped address
  output logic [NUM_PORTS-1:0]   HP_INBAND_O,   // events left for in-band signalling
  output logic                   GPIO7_O,       // pin 7 output value
  output logic                   GPIO7_OE_N_O   // pin 7 enable, low drives
);
  import gper_pkg::*;

  // the register layout has room for exactly four divert and status bits
  if (NUM_PORTS != `GPER_NUM_PORTS)
  begin : g_bad_ports
    $error("gper_router: port count must match the control layout");
  end

  localparam int PB = `GPER_FIRST_PORT_BIT;

  logic                 pol_invert_reg;
  logic [NUM_PORTS-1:0] divert_en_reg;
  logic                 pin_alt_reg;
  logic [NUM_PORTS-1:0] event_active_reg;
  logic [NUM_PORTS-1:0] event_active_next;
  logic                 any_event;
  gper_bus_state_t      bus_state_reg;
  logic                 req;
  logic                 wr_ctrl;
  logic                 wr_pincfg;
  logic                 mapped;
  logic                 rst_hold_reg;
  logic                 chk_off;

  assign req       = CYC_I && STB_I && (bus_state_reg == GPER_IDLE);
  assign mapped    = (ADR_I == `GPER_CTRL_OFS) || (ADR_I == `GPER_STAT_OFS)
                     || (ADR_I == `GPER_PINCFG_OFS);
  assign wr_ctrl   = req && WE_I && (ADR_I == `GPER_CTRL_OFS) && SEL_I[0];
  assign wr_pincfg = req && WE_I && (ADR_I == `GPER_PINCFG_OFS) && SEL_I[0];

  // control bits survive ordinary resets; only the power-on reset clears them
  always_ff @(posedge SYS_CLK_I or posedge STICKY_RST_I)
  begin
    if (STICKY_RST_I)
    begin
      pol_invert_reg <= 1'b0;
      divert_en_reg  <= '0;
      pin_alt_reg    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pol_invert_reg <= DAT_I[`GPER_POL_BIT];
        divert_en_reg  <= DAT_I[PB +: NUM_PORTS];
      end
      if (wr_pincfg)
        pin_alt_reg <= DAT_I[`GPER_PIN_ALT_BIT];
    end
  end

  // single wait state: ack in the cycle after the request is seen
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      bus_state_reg <= GPER_IDLE;
      ACK_O         <= 1'b0;
      ERR_O         <= 1'b0;
      DAT_O         <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= 1'b0;
      ERR_O <= 1'b0;
      case (bus_state_reg)
        GPER_IDLE:
        begin
          if (req)
          begin
            bus_state_reg <= GPER_ACK;
            ACK_O         <= mapped;
            ERR_O         <= !mapped;
            DAT_O         <= 32'h0000_0000;
            if (!WE_I && ADR_I == `GPER_CTRL_OFS)
              DAT_O <= {{(32-PB-NUM_PORTS){1'b0}}, divert_en_reg, 1'b0, pol_invert_reg};
            else if (!WE_I && ADR_I == `GPER_STAT_OFS)
              DAT_O <= {{(32-PB-NUM_PORTS){1'b0}}, event_active_reg, 2'b00}; // RQ5
            else if (!WE_I && ADR_I == `GPER_PINCFG_OFS)
              DAT_O <= {31'h0000_0000, pin_alt_reg};
          end
        end
        GPER_ACK:
          bus_state_reg <= GPER_IDLE;
        default:
          bus_state_reg <= GPER_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_port
      assign event_active_next[g] = HP_EVENT_I[g] && divert_en_reg[g]; // RQ3 RQ6
    end
  endgenerate

  assign any_event = |event_active_next; // RQ8

  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      event_active_reg <= '0;
      HP_INBAND_O      <= '0;
    end
    else
    begin
      event_active_reg <= event_active_next;
      HP_INBAND_O      <= HP_EVENT_I & ~divert_en_reg; // RQ2
    end
  end

  // pin idles deasserted at reset: active-low default means high
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      GPIO7_O      <= 1'b1;
      GPIO7_OE_N_O <= 1'b1;
    end
    else if (pin_alt_reg) // RQ4 RQ7
    begin
      GPIO7_O      <= pol_invert_reg ? any_event : !any_event; // RQ1 RQ8
      GPIO7_OE_N_O <= 1'b0;
    end
    else
    begin
      GPIO7_O      <= GPIO7_OUT_I;
      GPIO7_OE_N_O <= !GPIO7_DRV_I;
    end
  end

  // flops still sit in reset on the edge that releases it; checks wait one more edge
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      rst_hold_reg <= 1'b1;
    else
      rst_hold_reg <= 1'b0;
  end

  assign chk_off = RST_I || rst_hold_reg;

  status_needs_enable_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ6
    (|(event_active_reg & ~$past(divert_en_reg))) == 1'b0)
    else $error("status bit set without its divert bit");
  status_follows_event_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ5
    (HP_EVENT_I[0] && divert_en_reg[0]) |=> event_active_reg[0])
    else $error("status bit missed a diverted event");
  inband_suppressed_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ2
    divert_en_reg[1] |=> !HP_INBAND_O[1])
    else $error("diverted port still signalled in band");
  inband_passes_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ2
    (HP_EVENT_I[2] && !divert_en_reg[2]) |=> HP_INBAND_O[2])
    else $error("undiverted event lost");
  pin_low_active_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ1
    (pin_alt_reg && !pol_invert_reg && any_event) |=> (!GPIO7_O && !GPIO7_OE_N_O))
    else $error("active-low event not driven low");
  pin_high_active_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ1
    (pin_alt_reg && pol_invert_reg && !any_event) |=> !GPIO7_O)
    else $error("inverted idle level wrong");
  pin_or_ports_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ8
    (pin_alt_reg && !pol_invert_reg && $past(pin_alt_reg) && $past(!pol_invert_reg)) |->
      (GPIO7_O == !(|event_active_reg)))
    else $error("pin does not match or of port status");
  pin_gpio_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ7
    !pin_alt_reg |=> (GPIO7_O == $past(GPIO7_OUT_I)))
    else $error("event reached pin outside alternate function");
  pin_high_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ1
    (pin_alt_reg && pol_invert_reg && any_event) |=> (GPIO7_O && !GPIO7_OE_N_O))
    else $error("active-high event not driven high");
  pin_low_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ1
    (pin_alt_reg && !pol_invert_reg && !any_event) |=> GPIO7_O)
    else $error("active-low idle level wrong");
  gpio_drive_pass_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ7
    !pin_alt_reg |=> (GPIO7_OE_N_O == !$past(GPIO7_DRV_I)))
    else $error("pin drive outside alternate function not from gpio");
  alt_drives_pin_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ4
    pin_alt_reg |=> !GPIO7_OE_N_O)
    else $error("alternate function does not drive the pin");
  status_port_set_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ5
    (HP_EVENT_I[3] && divert_en_reg[3]) |=> event_active_reg[3])
    else $error("last port status missed a diverted event");
  status_port_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ6
    !divert_en_reg[3] |=> !event_active_reg[3])
    else $error("last port status set while not diverted");
  inband_mask_all_a: assert property (@(posedge SYS_CLK_I) disable iff (chk_off) // RQ2
    1'b1 |=> (HP_INBAND_O == ($past(HP_EVENT_I) & ~$past(divert_en_reg))))
    else $error("in-band events not masked by divert bits");
endmodule : gper_router

// *** gper_router_tb.sv ***
// self-checking bench for the event router
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module gper_router_tb;
  import gper_pkg::*;
  logic        clk = 0, rst = 1, srst = 1, we = 0, cyc = 0, stb = 0, gout = 0, gdrv = 0;
  logic [11:0] adr = '0;
  gper_word_t  wdat = '0, rdat, q;
  logic [3:0]  hp = '0, inb;
  logic        ack, err, pin, oe_n, seen, berr;
  int          n_errors = 0, samples_checked = 0, c = 0, alt, ev;
  always #5 clk = ~clk;
  gper_router i_dut (.SYS_CLK_I(clk), .RST_I(rst), .STICKY_RST_I(srst), .ADR_I(adr),
    .DAT_I(wdat), .SEL_I(4'hf), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .HP_EVENT_I(hp),
    .GPIO7_IN_I(1'b0), .GPIO7_OUT_I(gout), .GPIO7_DRV_I(gdrv), .DAT_O(rdat), .ACK_O(ack),
    .ERR_O(err), .HP_INBAND_O(inb), .GPIO7_O(pin), .GPIO7_OE_N_O(oe_n));
  gper_event_mon i_mon (.pin_i(pin), .oe_n_i(oe_n), .inv_i(c[0]), .event_o(seen));
  task automatic print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // classic single cycle; waits for ack or err, never a fixed count
  task automatic wb(input logic [11:0] a, input logic w, input gper_word_t d);
    int n;
    n = 0;
    adr  <= a;
    we   <= w;
    wdat <= d;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(ack || err) && n < 50);
    q    = rdat;
    berr = err;
    if (n >= 50)
    begin
      n_errors++;
      print_verdict();
    end
    cyc  <= 1'b0;
    stb  <= 1'b0;
    @(posedge clk);
  endtask : wb
  initial
  begin
    void'($urandom(32'h763f));
    repeat (6) @(posedge clk);
    rst  <= 1'b0;
    srst <= 1'b0;
    @(posedge clk);
    wb(12'h450, 0, 0);
    `CHK(q, 32'h0)
    wb(12'h454, 1, 32'h3c);
    wb(12'h454, 0, 0);
    `CHK(q, 32'h0)
    wb(12'h45c, 0, 0);
    `CHK(berr, 1'b1)
    repeat (40)
    begin
      c    = $urandom & 32'h3f;
      alt  = $urandom & 1;
      hp   <= 4'($urandom);
      gout <= 1'($urandom);
      gdrv <= 1'($urandom);
      wb(12'h450, 1, c);
      wb(12'h458, 1, alt);
      wb(12'h450, 0, 0);
      `CHK(q, gper_word_t'(c & 32'h3d))
      ev = hp & (c >> 2);
      wb(12'h454, 0, 0);
      `CHK(q, gper_word_t'(ev << 2))
      `CHK(inb, 4'(hp & ~(c >> 2)))
      `CHK(seen, 1'(alt ? ev != 0 : (gdrv ? gout : 1'b1) == c[0]))
      `CHK(oe_n, 1'(alt ? 0 : !gdrv))
      `CHK(pin, 1'(alt ? (ev != 0) == c[0] : gout))
    end
    // ordinary reset alone must keep the sticky control bits
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(12'h450, 0, 0);
    `CHK(q, gper_word_t'(c & 32'h3d))
    print_verdict();
  end
  initial
  begin
    #100000;
    n_errors++;
    print_verdict();
  end
endmodule : gper_router_tb
